// >>> rtl/cgm_mode_ctrl.sv
/*
 mode-control part of the clock generator: status/control, pll control and
 mode registers, mode decode, oscillator-ready, lock-loss flag and requests.
 assumes the analog loops, oscillator and clock monitor sit outside and report
 through pins; those pins are asynchronous and are synchronised here.
*/
module cgm_mode_ctrl
	import cgm_pkg::*;
#(
	parameter int OSC_INIT_CYCLES = CGM_OSC_INIT_CYCLES
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic osc_running,
	input wire logic fll_locked,
	input wire logic pll_locked,
	input wire logic lock_lost,
	input wire logic ext_clock_lost,
	input wire logic ext_ref_out_en,
	output logic lock_loss_irq,
	output logic clk_monitor_reset,
	output logic fll_enable,
	output logic pll_enable,
	output logic fll_drives_main,
	output logic [5:0] vco_multiplier_m,
	output logic fine_period_adjust,
	output cgm_mode_ctl_t mode_ctl,
	output cgm_mode_t fll_mode
);
	localparam int CW = $clog2(OSC_INIT_CYCLES + 1);

	logic [7:0] pll_control_reg, pll_control_next;
	cgm_mode_ctl_t mode_reg, mode_next;
	logic fine_trim_reg, fine_trim_next;
	logic osc_ready_reg, osc_ready_next;
	logic lock_loss_flag_reg, lock_loss_flag_next;
	logic lock_hold_reg, lock_hold_next;
	logic [CW-1:0] osc_cnt_reg, osc_cnt_next;
	logic [1:0] mode_status_reg, mode_status_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [4:0] s1_reg, s2_reg;
	logic osc_run_s, fll_lk_s, pll_lk_s, lol_s, ecl_s;
	logic pll_select, lock_now, ext_ref_used, internal_mode, wr_sc, wr_pc, wr_mc;
	logic lock_disturb;
	logic [1:0] active_src;
	cgm_mode_ctl_t wmode;

	// two-flop synchronisers for the analog status pins
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			s1_reg <= 5'h00;
			s2_reg <= 5'h00;
		end
		else
		begin
			s1_reg <= {ext_clock_lost, lock_lost, pll_locked, fll_locked, osc_running};
			s2_reg <= s1_reg;
		end
	end
	assign {ecl_s, lol_s, pll_lk_s, fll_lk_s, osc_run_s} = s2_reg;

	// decodes of bus strobes and control fields
	assign wr_sc = wr && (addr == CGM_OFF_STATUS_CONTROL);
	assign wr_pc = wr && (addr == CGM_OFF_PLL_CONTROL);
	assign wr_mc = wr && (addr == CGM_OFF_MODE_CONTROL);
	assign wmode = cgm_mode_ctl_t'(wdata);
	assign pll_select = pll_control_reg[CGM_PC_PLL_SELECT];
	assign pll_enable = pll_select;
	assign fll_enable = !pll_select;
	assign internal_mode = (fll_mode != CGM_FLL_EXTERNAL) && mode_reg.internal_ref_select;
	assign ext_ref_used = ext_ref_out_en || !mode_reg.internal_ref_select;
	assign lock_now = pll_select ? pll_lk_s : fll_lk_s;

	// mode decode of the three fll modes
	always_comb
	begin
		fll_mode = CGM_OTHER_MODE;
		if (!pll_select && mode_reg.clock_source_select == CGM_SRC_FLL)
		begin
			if (mode_reg.internal_ref_select && mode_reg.ref_divider == CGM_REF_DIVIDER_NONE)
				fll_mode = CGM_FLL_INTERNAL;
			else if (!mode_reg.internal_ref_select)
				fll_mode = CGM_FLL_EXTERNAL;
		end
		else if (!pll_select && mode_reg.clock_source_select == CGM_SRC_INTERNAL
			&& mode_reg.internal_ref_select && mode_reg.ref_divider == CGM_REF_DIVIDER_NONE
			&& !mode_reg.low_power_bypass)
			fll_mode = CGM_FLL_BYPASS_INTERNAL;
	end

	// main clock source: fll output in engaged modes, internal ref when bypassed
	always_comb
	begin
		case (fll_mode)
			CGM_FLL_INTERNAL: active_src = CGM_SRC_FLL;
			CGM_FLL_EXTERNAL: active_src = CGM_SRC_FLL;
			CGM_FLL_BYPASS_INTERNAL: active_src = CGM_SRC_INTERNAL;
			default: active_src = (pll_select && mode_reg.clock_source_select == CGM_SRC_FLL)
				? CGM_SRC_PLL : mode_reg.clock_source_select;
		endcase
	end
	assign fll_drives_main = (active_src == CGM_SRC_FLL);

	// vco multiplier: four times the code, reserved high codes clamp to forty
	always_comb
	begin
		if (pll_control_reg[CGM_PC_VCO_HI:0] > CGM_VCO_MAX_CODE)
			vco_multiplier_m = CGM_VCO_MAX_MULT;
		else
			vco_multiplier_m = {pll_control_reg[CGM_PC_VCO_HI:0], 2'b00};
	end

	// lock is disturbed by writes that change reference, loop or internal trim
	assign lock_disturb = (wr_mc && (wmode.internal_ref_select != mode_reg.internal_ref_select
		|| wmode.ref_divider != mode_reg.ref_divider))
		|| (wr_pc && wdata[CGM_PC_PLL_SELECT] != pll_select)
		|| (wr_sc && internal_mode && wdata[CGM_SC_FINE_TRIM] != fine_trim_reg);

	// next state of registers and status
	always_comb
	begin
		pll_control_next = wr_pc ? wdata : pll_control_reg;
		mode_next = wr_mc ? wmode : mode_reg;
		fine_trim_next = wr_sc ? wdata[CGM_SC_FINE_TRIM] : fine_trim_reg;
		// set beats the write-one clear when both land together
		lock_loss_flag_next = lock_loss_flag_reg;
		if (wr_sc && wdata[CGM_SC_LOCK_LOSS])
			lock_loss_flag_next = 1'b0;
		if (lol_s && lock_hold_reg)
			lock_loss_flag_next = 1'b1;
		// lock indication held low after a disturbing write until reacquired
		if (lock_disturb)
			lock_hold_next = 1'b0;
		else if (lock_hold_reg)
			lock_hold_next = lock_now;
		else
			lock_hold_next = lock_now && !lol_s;
		// oscillator init counter runs while requested and in use
		osc_cnt_next = osc_cnt_reg;
		osc_ready_next = osc_ready_reg;
		if (!mode_reg.ext_osc_request || (internal_mode && !ext_ref_out_en))
		begin
			osc_cnt_next = '0;
			osc_ready_next = 1'b0;
		end
		else if (ext_ref_used && osc_run_s && !osc_ready_reg)
		begin
			if (osc_cnt_reg == CW'(OSC_INIT_CYCLES - 1))
				osc_ready_next = 1'b1;
			else
				osc_cnt_next = osc_cnt_reg + 1'b1;
		end
		mode_status_next = active_src;
		// read data appears in the cycle after the read strobe
		rdata_next = 8'h00;
		if (rd)
		begin
			case (addr)
				CGM_OFF_STATUS_CONTROL: rdata_next = {lock_loss_flag_reg, lock_hold_reg,
					pll_select, mode_reg.internal_ref_select, mode_status_reg,
					osc_ready_reg, fine_trim_reg};
				CGM_OFF_PLL_CONTROL: rdata_next = pll_control_reg;
				CGM_OFF_MODE_CONTROL: rdata_next = 8'(mode_reg);
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// register stage
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			pll_control_reg <= CGM_RST_PLL_CONTROL;
			mode_reg <= cgm_mode_ctl_t'(CGM_RST_MODE_CONTROL);
			fine_trim_reg <= CGM_RST_FINE_TRIM;
			osc_ready_reg <= 1'b0;
			lock_loss_flag_reg <= 1'b0;
			lock_hold_reg <= 1'b0;
			osc_cnt_reg <= '0;
			mode_status_reg <= CGM_SRC_FLL;
			rdata_reg <= 8'h00;
		end
		else
		begin
			pll_control_reg <= pll_control_next;
			mode_reg <= mode_next;
			fine_trim_reg <= fine_trim_next;
			osc_ready_reg <= osc_ready_next;
			lock_loss_flag_reg <= lock_loss_flag_next;
			lock_hold_reg <= lock_hold_next;
			osc_cnt_reg <= osc_cnt_next;
			mode_status_reg <= mode_status_next;
			rdata_reg <= rdata_next;
		end
	end

	// outputs
	assign rdata = rdata_reg;
	assign lock_loss_irq = lock_loss_flag_reg && pll_control_reg[CGM_PC_LOL_IRQ_EN];
	assign clk_monitor_reset = ecl_s && pll_control_reg[CGM_PC_CLK_MON_EN];
	assign fine_period_adjust = fine_trim_reg;
	assign mode_ctl = mode_reg;

	// assertions: interrupt, loop select and clock monitor
	irq_gate_a: assert property (@(posedge clk) disable iff (!nrst)
		lock_loss_irq == (lock_loss_flag_reg && pll_control_reg[CGM_PC_LOL_IRQ_EN]))
		else $error("irq not gated by flag and enable");
	loop_excl_a: assert property (@(posedge clk) disable iff (!nrst)
		pll_enable != fll_enable) else $error("both loops enabled");
	mon_off_a: assert property (@(posedge clk) disable iff (!nrst)
		!pll_control_reg[CGM_PC_CLK_MON_EN] |-> !clk_monitor_reset)
		else $error("monitor reset while disabled");
	mon_on_a: assert property (@(posedge clk) disable iff (!nrst)
		ecl_s && pll_control_reg[CGM_PC_CLK_MON_EN] |-> clk_monitor_reset)
		else $error("monitor reset missing");
	// vco multiplier, including the reserved codes
	vco_clamp_a: assert property (@(posedge clk) disable iff (!nrst)
		pll_control_reg[CGM_PC_VCO_HI:0] > CGM_VCO_MAX_CODE |-> vco_multiplier_m == CGM_VCO_MAX_MULT)
		else $error("reserved vco code not forty");
	vco_scale_a: assert property (@(posedge clk) disable iff (!nrst)
		pll_control_reg[CGM_PC_VCO_HI:0] != 4'h0 && pll_control_reg[CGM_PC_VCO_HI:0] <= CGM_VCO_MAX_CODE
		|-> vco_multiplier_m == 6'(pll_control_reg[CGM_PC_VCO_HI:0]) * 6'h04)
		else $error("vco multiplier not four times code");
	// oscillator ready: set only after a counted start, dropped only for the two causes
	osc_set_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(osc_ready_reg) |-> $past(mode_reg.ext_osc_request) && $past(ext_ref_used)
		&& $past(osc_run_s) && $past(osc_cnt_reg) == CW'(OSC_INIT_CYCLES - 1))
		else $error("osc ready set too early");
	osc_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		!mode_reg.ext_osc_request |=> !osc_ready_reg)
		else $error("osc ready not cleared");
	osc_drop_a: assert property (@(posedge clk) disable iff (!nrst)
		$fell(osc_ready_reg) |-> !$past(nrst) || !$past(mode_reg.ext_osc_request)
		|| ($past(internal_mode) && !$past(ext_ref_out_en)))
		else $error("osc ready dropped without cause");
	// lock-loss flag and lock indication
	flag_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
		lock_loss_flag_reg && !(wr_sc && wdata[CGM_SC_LOCK_LOSS]) |=> lock_loss_flag_reg)
		else $error("lock loss flag dropped");
	flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
		lol_s && lock_hold_reg |=> lock_loss_flag_reg)
		else $error("lock loss not flagged");
	flag_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		!lock_loss_flag_reg && !(lol_s && lock_hold_reg) |=> !lock_loss_flag_reg)
		else $error("lock loss flag set without cause");
	lock_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		lock_disturb |=> !lock_hold_reg) else $error("lock not cleared");
	lock_ok_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(lock_hold_reg) |-> $past(lock_now) && !$past(lock_disturb))
		else $error("lock shown before reacquired");
	// mode decode, clock routing and reported status
	status_follow_a: assert property (@(posedge clk) disable iff (!nrst)
		$stable(active_src) |=> mode_status_reg == $past(active_src))
		else $error("mode status wrong");
	fll_int_a: assert property (@(posedge clk) disable iff (!nrst)
		!pll_select && mode_reg.clock_source_select == CGM_SRC_FLL && mode_reg.internal_ref_select
		&& mode_reg.ref_divider == CGM_REF_DIVIDER_NONE |-> fll_mode == CGM_FLL_INTERNAL)
		else $error("default mode not decoded");
	bypass_dec_a: assert property (@(posedge clk) disable iff (!nrst)
		fll_mode == CGM_FLL_BYPASS_INTERNAL |-> !mode_reg.low_power_bypass && !pll_select)
		else $error("bypass mode decoded with low power set");
	bypass_src_a: assert property (@(posedge clk) disable iff (!nrst)
		fll_mode == CGM_FLL_BYPASS_INTERNAL |-> !fll_drives_main && fll_enable)
		else $error("bypass mode main clock wrong");
	engaged_src_a: assert property (@(posedge clk) disable iff (!nrst)
		fll_mode == CGM_FLL_INTERNAL || fll_mode == CGM_FLL_EXTERNAL |-> fll_drives_main)
		else $error("engaged mode main clock not from fll");
	fll_loop_a: assert property (@(posedge clk) disable iff (!nrst)
		fll_mode != CGM_OTHER_MODE |-> fll_enable && !pll_enable)
		else $error("pll running in an fll mode");
	reset_mode_a: assert property (@(posedge clk) disable iff (!nrst)
		!$past(nrst) |-> fll_mode == CGM_FLL_INTERNAL && !osc_ready_reg)
		else $error("reset did not select fll engaged internal");
endmodule : cgm_mode_ctrl

// >>> pkg/cgm_pkg.sv
/*
 package for the clock generator mode-control block: register offsets,
 field positions, reset values, mode and clock-source encodings.
 assumes a single clock domain and a plain strobe register port.
*/
package cgm_pkg;
	// register offsets (index on the plain port)
	localparam logic [1:0] CGM_OFF_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] CGM_OFF_PLL_CONTROL = 2'h1;
	localparam logic [1:0] CGM_OFF_MODE_CONTROL = 2'h2;
	// clock_status_control field positions
	localparam int CGM_SC_LOCK_LOSS = 7;
	localparam int CGM_SC_LOCK = 6;
	localparam int CGM_SC_PLL_STATUS = 5;
	localparam int CGM_SC_IREF_STATUS = 4;
	localparam int CGM_SC_MODE_HI = 3;
	localparam int CGM_SC_MODE_LO = 2;
	localparam int CGM_SC_OSC_READY = 1;
	localparam int CGM_SC_FINE_TRIM = 0;
	// pll_control field positions
	localparam int CGM_PC_LOL_IRQ_EN = 7;
	localparam int CGM_PC_PLL_SELECT = 6;
	localparam int CGM_PC_CLK_MON_EN = 5;
	localparam int CGM_PC_VCO_HI = 3;
	// mode_control field positions
	localparam int CGM_MC_CLKSRC_LO = 0;
	localparam int CGM_MC_IREF_SEL = 2;
	localparam int CGM_MC_REF_DIVIDER_LO = 3;
	localparam int CGM_MC_LOW_POWER = 6;
	localparam int CGM_MC_EXT_OSC_REQ = 7;
	// reset values: fll engaged internal
	localparam logic [7:0] CGM_RST_PLL_CONTROL = 8'h01;
	localparam logic [7:0] CGM_RST_MODE_CONTROL = 8'h04;
	localparam logic CGM_RST_FINE_TRIM = 1'b0;
	// clock source select / mode status encodings
	localparam logic [1:0] CGM_SRC_FLL = 2'h0;
	localparam logic [1:0] CGM_SRC_INTERNAL = 2'h1;
	localparam logic [1:0] CGM_SRC_EXTERNAL = 2'h2;
	localparam logic [1:0] CGM_SRC_PLL = 2'h3;
	localparam logic [2:0] CGM_REF_DIVIDER_NONE = 3'h0;
	// vco multiplier limits, fll lock ratio
	localparam logic [3:0] CGM_VCO_MAX_CODE = 4'hA;
	localparam logic [5:0] CGM_VCO_MAX_MULT = 6'h28;
	localparam int CGM_FLL_RATIO = 1024;
	// oscillator initialization cycles
	localparam int CGM_OSC_INIT_CYCLES = 4096;

	typedef enum logic [2:0] {
		CGM_FLL_INTERNAL,
		CGM_FLL_EXTERNAL,
		CGM_FLL_BYPASS_INTERNAL,
		CGM_OTHER_MODE
	} cgm_mode_t;

	// msb first so the struct lines up with the mode_control field positions above
	typedef struct packed {
		logic ext_osc_request;
		logic low_power_bypass;
		logic [2:0] ref_divider;
		logic internal_ref_select;
		logic [1:0] clock_source_select;
	} cgm_mode_ctl_t;
endpackage : cgm_pkg

// >>> bench/cgm_osc_model.sv
/*
 stand-in for the oscillator, the fll/pll lock detectors and the clock monitor.
 assumes the bench raises lose_lock and lose_clock to inject faults.
*/
module cgm_osc_model
	import cgm_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic osc_request,
	input wire logic fll_enable,
	input wire logic pll_enable,
	input wire logic lose_lock,
	input wire logic lose_clock,
	output logic osc_running,
	output logic fll_locked,
	output logic pll_locked,
	output logic lock_lost,
	output logic ext_clock_lost
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] start_reg;
	// a real crystal needs time to start, so running lags the request
	always_ff @(posedge clk)
		if (!nrst || !osc_request)
			start_reg <= 2'h0;
		else if (start_reg != 2'h3)
			start_reg <= start_reg + 2'h1;
	// loops report lock only while enabled; faults come from the bench
	assign osc_running = (start_reg == 2'h3);
	assign fll_locked = fll_enable;
	assign pll_locked = pll_enable;
	assign lock_lost = lose_lock;
	assign ext_clock_lost = lose_clock;
endmodule : cgm_osc_model

// >>> bench/tb.sv
/*
 self-checking bench for the clock generator mode control.
 assumes cgm_osc_model stands in for the oscillator and the loops.
*/
module tb
	import cgm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ext_ref_out_en = 1'b0;
	logic lose_lock = 1'b0;
	logic lose_clock = 1'b0;
	logic [7:0] rdata, d;
	logic osc_running, fll_locked, pll_locked, lock_lost, ext_clock_lost;
	logic lock_loss_irq, clk_monitor_reset, fll_enable, pll_enable, fll_drives_main;
	logic [5:0] vco_multiplier_m;
	logic fine_period_adjust;
	cgm_mode_ctl_t mode_ctl;
	cgm_mode_t fll_mode;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;
	// short init count keeps the oscillator wait brief
	cgm_mode_ctrl #(.OSC_INIT_CYCLES(8)) dut (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_running(osc_running),
		.fll_locked(fll_locked), .pll_locked(pll_locked), .lock_lost(lock_lost),
		.ext_clock_lost(ext_clock_lost), .ext_ref_out_en(ext_ref_out_en),
		.lock_loss_irq(lock_loss_irq), .clk_monitor_reset(clk_monitor_reset),
		.fll_enable(fll_enable), .pll_enable(pll_enable), .fll_drives_main(fll_drives_main),
		.vco_multiplier_m(vco_multiplier_m), .fine_period_adjust(fine_period_adjust),
		.mode_ctl(mode_ctl), .fll_mode(fll_mode));
	cgm_osc_model partner (.clk(clk), .nrst(nrst), .osc_request(mode_ctl.ext_osc_request),
		.fll_enable(fll_enable), .pll_enable(pll_enable), .lose_lock(lose_lock),
		.lose_clock(lose_clock), .osc_running(osc_running), .fll_locked(fll_locked),
		.pll_locked(pll_locked), .lock_lost(lock_lost), .ext_clock_lost(ext_clock_lost));
	// 250 MHz
	initial
		forever #2 clk = ~clk;
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe, so take them mid-cycle
	task automatic rd_reg(input logic [1:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd_reg
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic t_reset();
		rd_reg(CGM_OFF_PLL_CONTROL);
		chk("pll_control", 8'h01, d);
		rd_reg(CGM_OFF_MODE_CONTROL);
		chk("mode_control", 8'h04, d);
		chk("fll_mode", {5'h00, CGM_FLL_INTERNAL}, {5'h00, fll_mode});
		chk("loops", 8'h02, {6'h00, fll_enable, pll_enable});
		rd_reg(2'h3);
		chk("unmapped", 8'h00, d);
		$display("test reset done");
	endtask : t_reset
	task automatic t_vco();
		for (int c = 0; c < 16; c++)
		begin
			wr_reg(CGM_OFF_PLL_CONTROL, 8'(c));
			idle(1);
			chk("vco_m", (c == 0) ? 8'h00 : (c > 10) ? 8'h28 : 8'(4 * c), {2'h0, vco_multiplier_m});
		end
		wr_reg(CGM_OFF_PLL_CONTROL, 8'h41);
		idle(1);
		chk("loops", 8'h01, {6'h00, fll_enable, pll_enable});
		rd_reg(CGM_OFF_STATUS_CONTROL);
		chk("pll_status", 8'h07, {5'h00, d[5], d[3:2]});
		chk("lock", 8'h00, {7'h00, d[6]});
		wr_reg(CGM_OFF_PLL_CONTROL, 8'h01);
		idle(1);
		chk("loops", 8'h02, {6'h00, fll_enable, pll_enable});
		$display("test vco done");
	endtask : t_vco
	// one mode setting: decode, main clock source and reported status
	task automatic t_mode(input logic [7:0] v, input cgm_mode_t m, input logic [1:0] st);
		wr_reg(CGM_OFF_MODE_CONTROL, v);
		idle(4);
		chk("mode_ctl", v, mode_ctl);
		chk("fll_mode", {5'h00, m}, {5'h00, fll_mode});
		chk("main", {7'h00, st == 2'h0}, {7'h00, fll_drives_main});
		rd_reg(CGM_OFF_STATUS_CONTROL);
		chk("status", {6'h00, st}, {6'h00, d[3:2]});
	endtask : t_mode
	task automatic t_modes();
		t_mode(8'h00, CGM_FLL_EXTERNAL, 2'h0);
		t_mode(8'h05, CGM_FLL_BYPASS_INTERNAL, 2'h1);
		t_mode(8'h45, CGM_OTHER_MODE, 2'h1);
		t_mode(8'h0C, CGM_OTHER_MODE, 2'h0);
		t_mode(8'h04, CGM_FLL_INTERNAL, 2'h0);
		$display("test modes done");
	endtask : t_modes
	task automatic t_osc();
		wr_reg(CGM_OFF_MODE_CONTROL, 8'h80);
		idle(30);
		rd_reg(CGM_OFF_STATUS_CONTROL);
		chk("osc_ready", 8'h01, {7'h00, d[1]});
		wr_reg(CGM_OFF_PLL_CONTROL, 8'h21);
		lose_clock <= 1'b1;
		idle(5);
		chk("monitor", 8'h01, {7'h00, clk_monitor_reset});
		wr_reg(CGM_OFF_PLL_CONTROL, 8'h01);
		idle(1);
		chk("monitor", 8'h00, {7'h00, clk_monitor_reset});
		lose_clock <= 1'b0;
		ext_ref_out_en <= 1'b1;
		wr_reg(CGM_OFF_MODE_CONTROL, 8'h84);
		idle(3);
		rd_reg(CGM_OFF_STATUS_CONTROL);
		chk("osc_ready", 8'h01, {7'h00, d[1]});
		@(posedge clk);
		ext_ref_out_en <= 1'b0;
		idle(3);
		rd_reg(CGM_OFF_STATUS_CONTROL);
		chk("osc_ready", 8'h00, {7'h00, d[1]});
		$display("test oscillator done");
	endtask : t_osc
	task automatic t_lock();
		wr_reg(CGM_OFF_PLL_CONTROL, 8'h81);
		idle(8);
		@(posedge clk);
		lose_lock <= 1'b1;
		idle(2);
		@(posedge clk);
		lose_lock <= 1'b0;
		idle(4);
		rd_reg(CGM_OFF_STATUS_CONTROL);
		chk("flag", 8'h01, {7'h00, d[7]});
		chk("irq", 8'h01, {7'h00, lock_loss_irq});
		wr_reg(CGM_OFF_STATUS_CONTROL, 8'h01);
		idle(1);
		chk("trim", 8'h01, {7'h00, fine_period_adjust});
		rd_reg(CGM_OFF_STATUS_CONTROL);
		chk("flag", 8'h01, {7'h00, d[7]});
		wr_reg(CGM_OFF_PLL_CONTROL, 8'h01);
		idle(1);
		chk("irq", 8'h00, {7'h00, lock_loss_irq});
		wr_reg(CGM_OFF_STATUS_CONTROL, 8'h80);
		rd_reg(CGM_OFF_STATUS_CONTROL);
		chk("flag_trim", 8'h00, {6'h00, d[7], d[0]});
		$display("test lock loss done");
	endtask : t_lock
	// the whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			stop_test();
		end
	end
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_vco();
		t_modes();
		t_osc();
		t_lock();
		stop_test();
	end
endmodule : tb
